/* verilog/icfg_top.sv */
`timescale 1ns/100ps
`default_nettype none

`include "icfg_defs.svh"

// What this block does
// - outside-threshold event wakes when enabled
// - orientation change wakes when enabled
// - level data-ready held until output read
// - pulse option gives 32 us pulse
// - pulse ORed with other pin events
// - boot mode ignores pulse option
// - function select 0: pin two outputs
// - trigger edge starts single or full
// - trigger enable shown in system status
// - trigger mode: events routed to pin two dropped, pin input
// - boot mode ignores function select
// - driver bit: push-pull or open
// - polarity, driver survive soft reset
// - boot mode forces open-drain drivers
// - polarity bit sets active level
// - boot mode forces active low
// - open drive asserts, else floats
module icfg_top #(
   parameter int CNT_W        = 16,
   parameter int PULSE_CYCLES = `ICFG_DRDY_PULSE_NS / `ICFG_CLK_PERIOD_NS,
   parameter int N_EXTRA      = 5
) (
   // clock and reset
   input  wire logic               CLK_I,
   input  wire logic               ARST_N_I,
   // register port
   input  wire logic [7:0]         ADDR_I,
   input  wire logic [7:0]         WDATA_I,
   input  wire logic               WR_I,
   input  wire logic               RD_I,
   output logic      [7:0]         RDATA_O,
   // device control
   input  wire logic               SOFT_RESET_I,
   input  wire logic               HIBERNATE_I,
   input  wire logic               DATA_READ_I,
   // detection events
   input  wire logic               DATA_READY_EVENT_I,
   input  wire logic               OUTSIDE_THR_EVENT_I,
   input  wire logic               ORIENT_EVENT_I,
   input  wire logic [N_EXTRA-1:0] EXTRA_EVENTS_I,
   // pins
   input  wire logic               BOOT_MODE_STRAP_I,
   input  wire logic               IRQ2_PIN_I,
   output logic                    IRQ1_O,
   output logic                    IRQ1_OE_O,
   output logic                    IRQ2_O,
   output logic                    IRQ2_OE_O,
   // to the measurement and power logic
   output logic                    WAKE_HOLD_O,
   output logic                    TRIG_SINGLE_O,
   output logic                    TRIG_FULL_O,
   output logic                    IRQ_O
);

   localparam int NEV = 3 + N_EXTRA;

   // registers
   logic [7:0]                  cfg4_reg;
   logic [7:0]                  cfg4_next;
   logic [NEV-1:0]              status_reg;
   logic [NEV-1:0]              status_next;
   logic [NEV-1:0]              mask_reg;
   logic [NEV-1:0]              mask_next;
   logic [NEV-1:0]              route_reg;
   logic [NEV-1:0]              route_next;
   logic [7:0]                  rdata_reg;
   logic [7:0]                  rdata_next;
   logic                        boot_reg;
   logic                        strap_done_reg;
   logic [1:0]                  strap_cnt_reg;
   icfg_pkg::icfg_pulse_state_t pulse_state_reg;
   icfg_pkg::icfg_pulse_state_t pulse_state_next;
   logic [CNT_W-1:0]            pulse_cnt_reg;
   logic [CNT_W-1:0]            pulse_cnt_next;
   logic [1:0]                  pin_out_reg;
   logic [1:0]                  pin_oe_reg;
   logic [1:0]                  pin_out_next;
   logic [1:0]                  pin_oe_next;
   logic                        wake_reg;
   logic                        wake_next;
   logic                        trig_single_reg;
   logic                        trig_full_reg;
   logic                        trig_single_next;
   logic                        trig_full_next;
   logic                        irq_reg;
   logic                        irq_next;

   // decode
   logic                        wr_cfg4;
   logic                        wr_status;
   logic                        wr_mask;
   logic                        wr_route;
   logic                        rd_cfg4;
   logic                        rd_status;
   logic                        rd_mask;
   logic                        rd_route;
   logic                        rd_sysmode;
   logic [7:0]                  sysmode_val;
   logic [7:0]                  status_rd;
   logic [7:0]                  mask_rd;
   logic [7:0]                  route_rd;

   // config views
   logic                        polarity;
   logic                        drv_open;
   logic                        pulse_mode;
   logic                        trig_en;
   logic                        trig_mode;

   // events and pins
   logic [NEV-1:0]              ev_vec;
   logic [NEV-1:0]              st_clr;
   logic [NEV-1:0]              level_src;
   logic [1:0]                  pin_act;
   logic                        pulse_start;
   logic                        pulse_active;
   logic                        pulse_cnt_zero;
   logic                        strap_level;
   logic                        trig_rise;
   icfg_pkg::icfg_drive_t       drv_mode [2];

   // synchronisers for the pins
   icfg_sync u_strap_sync (
      .clk_i    (CLK_I),
      .arst_n_i (ARST_N_I),
      .async_i  (BOOT_MODE_STRAP_I),
      .level_o  (strap_level),
      .rise_o   ()
   );

   icfg_sync u_trig_sync (
      .clk_i    (CLK_I),
      .arst_n_i (ARST_N_I),
      .async_i  (IRQ2_PIN_I),
      .level_o  (),
      .rise_o   (trig_rise)
   );

   // register decode
   assign wr_cfg4    = WR_I & (ADDR_I == `ICFG_ADDR_CFG4);
   assign wr_status  = WR_I & (ADDR_I == `ICFG_ADDR_STATUS);
   assign wr_mask    = WR_I & (ADDR_I == `ICFG_ADDR_MASK);
   assign wr_route   = WR_I & (ADDR_I == `ICFG_ADDR_ROUTE);
   assign rd_cfg4    = RD_I & (ADDR_I == `ICFG_ADDR_CFG4);
   assign rd_status  = RD_I & (ADDR_I == `ICFG_ADDR_STATUS);
   assign rd_mask    = RD_I & (ADDR_I == `ICFG_ADDR_MASK);
   assign rd_route   = RD_I & (ADDR_I == `ICFG_ADDR_ROUTE);
   assign rd_sysmode = RD_I & (ADDR_I == `ICFG_ADDR_SYSMODE);

   // config views; boot mode overrides several bits
   assign polarity   = cfg4_reg[`ICFG_B_POLARITY];
   assign drv_open   = cfg4_reg[`ICFG_B_DRV_TYPE];
   assign pulse_mode = cfg4_reg[`ICFG_B_PULSE_OPT] & ~boot_reg;
   assign trig_en    = cfg4_reg[`ICFG_B_FUNC_SEL] & ~boot_reg;
   assign trig_mode  = cfg4_reg[`ICFG_B_TRIG_MODE];

   // system mode status
   always_comb begin
      sysmode_val                = `ICFG_ZERO_RESET;
      sysmode_val[`ICFG_SM_TRIG] = trig_en;
      sysmode_val[`ICFG_SM_BOOT] = boot_reg;
   end

   // read mux; unmapped offsets read zero
   assign status_rd = 8'(status_reg);
   assign mask_rd   = 8'(mask_reg);
   assign route_rd  = 8'(route_reg);
   assign rdata_next = rd_cfg4    ? cfg4_reg    :
                       rd_status  ? status_rd   :
                       rd_mask    ? mask_rd     :
                       rd_route   ? route_rd    :
                       rd_sysmode ? sysmode_val :
                       `ICFG_ZERO_RESET;

   // hibernate loses everything; soft reset keeps polarity and driver type
   assign cfg4_next = HIBERNATE_I  ? `ICFG_CFG4_RESET :
                      SOFT_RESET_I ? ((cfg4_reg & `ICFG_CFG4_KEEP) |
                                      (`ICFG_CFG4_RESET & ~`ICFG_CFG4_KEEP)) :
                      wr_cfg4      ? WDATA_I :
                      cfg4_reg;

   assign mask_next  = (HIBERNATE_I | SOFT_RESET_I) ? '0 :
                       wr_mask ? WDATA_I[NEV-1:0] : mask_reg;
   assign route_next = (HIBERNATE_I | SOFT_RESET_I) ? '0 :
                       wr_route ? WDATA_I[NEV-1:0] : route_reg;

   // event status, write one to clear; a new event beats the clear
   assign ev_vec = {EXTRA_EVENTS_I, ORIENT_EVENT_I, OUTSIDE_THR_EVENT_I, DATA_READY_EVENT_I};

   genvar gi;
   generate
      for (gi = 0; gi < NEV; gi++) begin : g_status
         if (gi == `ICFG_EV_DRDY) begin : g_drdy
            // data-ready level also drops when the host reads the output data
            assign st_clr[gi] = (wr_status & WDATA_I[gi]) | DATA_READ_I;
         end else begin : g_other
            assign st_clr[gi] = wr_status & WDATA_I[gi];
         end
         assign status_next[gi] = (HIBERNATE_I | SOFT_RESET_I) ? 1'b0 :
                                  ev_vec[gi] | (status_reg[gi] & ~st_clr[gi]);
      end
   endgenerate

   // pin sources: in pulse mode the data-ready level is replaced by the pulse
   always_comb begin
      level_src = status_reg & mask_reg;
      if (pulse_mode) begin
         level_src[`ICFG_EV_DRDY] = 1'b0;
      end
   end

   // route bit 1 sends an event to pin two, 0 to pin one
   assign pin_act[0] = (|(level_src & ~route_reg)) |
                       (pulse_active & ~route_reg[`ICFG_EV_DRDY]);
   assign pin_act[1] = ~trig_en &
                       ((|(level_src & route_reg)) |
                        (pulse_active & route_reg[`ICFG_EV_DRDY]));

   assign irq_next = |(status_reg & mask_reg);

   // data-ready pulse timer; a new event restarts it
   assign pulse_start    = DATA_READY_EVENT_I & pulse_mode & mask_reg[`ICFG_EV_DRDY];
   assign pulse_active   = (pulse_state_reg == icfg_pkg::PS_PULSE);
   assign pulse_cnt_zero = (pulse_cnt_reg == '0);

   always_comb begin
      pulse_state_next = pulse_state_reg;
      pulse_cnt_next   = pulse_cnt_reg;
      unique case (pulse_state_reg)
         icfg_pkg::PS_IDLE: begin
            if (pulse_start) begin
               pulse_state_next = icfg_pkg::PS_PULSE;
               pulse_cnt_next   = CNT_W'(PULSE_CYCLES - 1);
            end
         end
         icfg_pkg::PS_PULSE: begin
            if (pulse_start) begin
               pulse_cnt_next = CNT_W'(PULSE_CYCLES - 1);
            end else if (pulse_cnt_zero || !pulse_mode) begin
               pulse_state_next = icfg_pkg::PS_IDLE;
               pulse_cnt_next   = '0;
            end else begin
               pulse_cnt_next = pulse_cnt_reg - CNT_W'(1);
            end
         end
      endcase
   end

   // driver selection per pin
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         assign drv_mode[gi] = boot_reg            ? icfg_pkg::DRV_BOOT   :
                               (gi == 1 && trig_en) ? icfg_pkg::DRV_INPUT :
                               drv_open            ? icfg_pkg::DRV_OPEN   :
                               icfg_pkg::DRV_PUSH_PULL;
         // push-pull drives the polarity-adjusted level
         assign pin_oe_next[gi] = (drv_mode[gi] == icfg_pkg::DRV_INPUT)     ? 1'b0 :
                                  (drv_mode[gi] == icfg_pkg::DRV_PUSH_PULL) ? 1'b1 :
                                  pin_act[gi];
         assign pin_out_next[gi] = (drv_mode[gi] == icfg_pkg::DRV_PUSH_PULL) ?
                                   ~(pin_act[gi] ^ polarity) :
                                   (drv_mode[gi] == icfg_pkg::DRV_OPEN) ?
                                   polarity : 1'b0;
      end
   endgenerate

   // wake sources
   assign wake_next = (OUTSIDE_THR_EVENT_I & cfg4_reg[`ICFG_B_WAKE_OT]) |
                      (ORIENT_EVENT_I & cfg4_reg[`ICFG_B_WAKE_OR]);

   // one edge starts the whole decimated measurement in full mode
   assign trig_full_next   = trig_rise & trig_en & trig_mode;
   assign trig_single_next = trig_rise & trig_en & ~trig_mode;

   // strap is caught once the synchroniser has settled after reset
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         strap_cnt_reg  <= 2'h0;
         strap_done_reg <= 1'b0;
         boot_reg       <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == `ICFG_STRAP_SETTLE) begin
            strap_done_reg <= 1'b1;
            boot_reg       <= strap_level;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cfg4_reg   <= `ICFG_CFG4_RESET;
         status_reg <= '0;
         mask_reg   <= '0;
         route_reg  <= '0;
         rdata_reg  <= `ICFG_ZERO_RESET;
      end else begin
         cfg4_reg   <= cfg4_next;
         status_reg <= status_next;
         mask_reg   <= mask_next;
         route_reg  <= route_next;
         rdata_reg  <= rdata_next;
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pulse_state_reg <= icfg_pkg::PS_IDLE;
         pulse_cnt_reg   <= '0;
      end else begin
         pulse_state_reg <= pulse_state_next;
         pulse_cnt_reg   <= pulse_cnt_next;
      end
   end

   // pins idle low and undriven during reset, before polarity applies
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pin_out_reg     <= 2'h0;
         pin_oe_reg      <= 2'h0;
         wake_reg        <= 1'b0;
         trig_single_reg <= 1'b0;
         trig_full_reg   <= 1'b0;
         irq_reg         <= 1'b0;
      end else begin
         pin_out_reg     <= pin_out_next;
         pin_oe_reg      <= pin_oe_next;
         wake_reg        <= wake_next;
         trig_single_reg <= trig_single_next;
         trig_full_reg   <= trig_full_next;
         irq_reg         <= irq_next;
      end
   end

   assign RDATA_O       = rdata_reg;
   assign IRQ1_O        = pin_out_reg[0];
   assign IRQ1_OE_O     = pin_oe_reg[0];
   assign IRQ2_O        = pin_out_reg[1];
   assign IRQ2_OE_O     = pin_oe_reg[1];
   assign WAKE_HOLD_O   = wake_reg;
   assign TRIG_SINGLE_O = trig_single_reg;
   assign TRIG_FULL_O   = trig_full_reg;
   assign IRQ_O         = irq_reg;

endmodule : icfg_top

`default_nettype wire

/* verilog/icfg_defs.svh */
`ifndef ICFG_DEFS_SVH
`define ICFG_DEFS_SVH

// register offsets
`define ICFG_ADDR_CFG4      8'h18
`define ICFG_ADDR_STATUS    8'h30
`define ICFG_ADDR_MASK      8'h31
`define ICFG_ADDR_ROUTE     8'h32
`define ICFG_ADDR_SYSMODE   8'h33

// reset values
`define ICFG_CFG4_RESET     8'h01
`define ICFG_ZERO_RESET     8'h00
// polarity and driver type survive a soft reset
`define ICFG_CFG4_KEEP      8'h03

// sensor_config_four fields
`define ICFG_B_TRIG_MODE    7
`define ICFG_B_WAKE_WT      6
`define ICFG_B_WAKE_OT      5
`define ICFG_B_WAKE_OR      4
`define ICFG_B_PULSE_OPT    3
`define ICFG_B_FUNC_SEL     2
`define ICFG_B_DRV_TYPE     1
`define ICFG_B_POLARITY     0

// event status bit positions
`define ICFG_EV_DRDY        0
`define ICFG_EV_OT          1
`define ICFG_EV_OR          2

// system_mode_status fields
`define ICFG_SM_TRIG        0
`define ICFG_SM_BOOT        1

// timing
`define ICFG_CLK_PERIOD_NS  4
`define ICFG_DRDY_PULSE_NS  32000
`define ICFG_STRAP_SETTLE   2'h3

`endif

/* verilog/icfg_pkg.sv */
`default_nettype none

package icfg_pkg;

   typedef enum logic {
      PS_IDLE  = 1'b0,
      PS_PULSE = 1'b1
   } icfg_pulse_state_t;

   typedef enum logic [1:0] {
      DRV_PUSH_PULL = 2'b00,
      DRV_OPEN      = 2'b01,
      DRV_BOOT      = 2'b10,
      DRV_INPUT     = 2'b11
   } icfg_drive_t;

endpackage : icfg_pkg

`default_nettype wire

/* verilog/icfg_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module icfg_sync (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   // asynchronous level in
   input  wire logic async_i,
   // synchronised level and its rising edge
   output logic      level_o,
   output logic      rise_o
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // meta_reg is read only by sync_reg
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign rise_o  = sync_reg & ~last_reg;

endmodule : icfg_sync

`default_nettype wire

/* sim/icfg_props.sv */
`timescale 1ns/100ps
`default_nettype none
`include "icfg_defs.svh"
module icfg_props (
   // clock and reset
   input wire logic       CLK_I,
   input wire logic       ARST_N_I,
   // register writes
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic       WR_I,
   // control, events, pins
   input wire logic       SOFT_RESET_I,
   input wire logic       HIBERNATE_I,
   input wire logic       OUTSIDE_THR_EVENT_I,
   input wire logic       ORIENT_EVENT_I,
   input wire logic       BOOT_MODE_STRAP_I,
   input wire logic       IRQ2_PIN_I,
   // outputs watched
   input wire logic       IRQ1_O,
   input wire logic       IRQ1_OE_O,
   input wire logic       IRQ2_OE_O,
   input wire logic       WAKE_HOLD_O,
   input wire logic       TRIG_SINGLE_O,
   input wire logic       TRIG_FULL_O,
   input wire logic       IRQ_O
);
   logic [7:0] cfg_reg;
   logic [7:0] cfg_q_reg;
   logic [7:0] rt_reg;
   logic [7:0] rt_q_reg;
   logic [2:0] cyc_reg;
   wire        steady = cfg_reg == cfg_q_reg && rt_reg == rt_q_reg;
   wire        normal = cyc_reg == 3'h7 && !BOOT_MODE_STRAP_I;
   wire        boot   = cyc_reg == 3'h7 && BOOT_MODE_STRAP_I;
   wire        cause  = (OUTSIDE_THR_EVENT_I && cfg_reg[5]) || (ORIENT_EVENT_I && cfg_reg[4]);
   wire        trig   = TRIG_SINGLE_O || TRIG_FULL_O;

   // shadow config; the strap is only trusted once the capture has surely happened
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cfg_reg   <= 8'h01;
         cfg_q_reg <= 8'h01;
         rt_reg    <= 8'h00;
         rt_q_reg  <= 8'h00;
         cyc_reg   <= 3'h0;
      end else begin
         cfg_q_reg <= cfg_reg;
         rt_q_reg  <= rt_reg;
         if (cyc_reg != 3'h7) cyc_reg <= cyc_reg + 3'h1;
         if (HIBERNATE_I) begin
            cfg_reg <= 8'h01;
            rt_reg  <= 8'h00;
         end else if (SOFT_RESET_I) begin
            cfg_reg <= {6'h00, cfg_reg[1:0]};
            rt_reg  <= 8'h00;
         end else if (WR_I && ADDR_I == `ICFG_ADDR_CFG4) begin
            cfg_reg <= WDATA_I;
         end else if (WR_I && ADDR_I == `ICFG_ADDR_ROUTE) begin
            rt_reg <= WDATA_I;
         end
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);

   property p_wake_cause;
      cause |=> WAKE_HOLD_O;
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake hold missing");
   property p_wake_only;
      WAKE_HOLD_O |-> $past(cause);
   endproperty
   a_wake_only: assert property (p_wake_only) else $error("wake hold without cause");
   property p_trig_edge;
      $rose(IRQ2_PIN_I) && cfg_reg[2] && normal |->
         ##3 (cfg_reg[7] ? TRIG_FULL_O && !TRIG_SINGLE_O : TRIG_SINGLE_O && !TRIG_FULL_O);
   endproperty
   a_trig_edge: assert property (p_trig_edge) else $error("trigger start wrong");
   property p_trig_once;
      trig |=> !trig;
   endproperty
   a_trig_once: assert property (p_trig_once) else $error("trigger start too long");
   property p_trig_cause;
      trig |-> normal && cfg_reg[2];
   endproperty
   a_trig_cause: assert property (p_trig_cause) else $error("trigger while off");
   property p_pin2_in;
      cfg_reg[2] && normal && steady |-> !IRQ2_OE_O;
   endproperty
   a_pin2_in: assert property (p_pin2_in) else $error("pin two driven as input");
   property p_pin1_pp;
      normal && steady && cfg_reg[3:1] == 3'h0 && rt_reg == 8'h00
         |-> IRQ1_OE_O && IRQ1_O == (IRQ_O ~^ cfg_reg[0]);
   endproperty
   a_pin1_pp: assert property (p_pin1_pp) else $error("push-pull level wrong");
   property p_pin1_od;
      normal && steady && cfg_reg[1] && !cfg_reg[3] && rt_reg == 8'h00
         |-> IRQ1_O == cfg_reg[0] && IRQ1_OE_O == IRQ_O;
   endproperty
   a_pin1_od: assert property (p_pin1_od) else $error("open drive wrong");
   property p_boot;
      boot && steady && rt_reg == 8'h00 |-> !IRQ1_O && IRQ1_OE_O == IRQ_O;
   endproperty
   a_boot: assert property (p_boot) else $error("boot drive wrong");
endmodule : icfg_props

bind icfg_top icfg_props u_props (.*);
`default_nettype wire

/* sim/icfg_host.sv */
`timescale 1ns/100ps
`default_nettype none
module icfg_host (
   // clock and bench commands
   input  wire logic clk_i,
   input  wire logic trig_req_i,
   input  wire logic drive_i,
   // device side of pin two
   input  wire logic dev_out_i,
   input  wire logic dev_oe_i,
   output logic      pin_o
);
   logic       lvl_reg  = 1'b0;
   logic [2:0] hold_reg = 3'h0;
   // one rising edge is all a decimated measurement needs
   always_ff @(posedge clk_i) begin
      if (trig_req_i) begin
         lvl_reg  <= 1'b1;
         hold_reg <= 3'h4;
      end else if (hold_reg != 3'h0) begin
         hold_reg <= hold_reg - 3'h1;
      end else begin
         lvl_reg <= 1'b0;
      end
   end
   // the external pull holds the deasserted level, the inverse of what the driver asserts
   assign pin_o = dev_oe_i ? dev_out_i : (drive_i ? lvl_reg : ~dev_out_i);
endmodule : icfg_host
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "icfg_defs.svh"
module tb;
   localparam int PC = 8;
   logic       clk, arst_n, wr, rd, srst, hib, dread, ev_dr, ev_ot, ev_or, strap, treq, tdrv;
   logic [7:0] addr, wdata, v;
   logic [4:0] ev_x;
   logic [7:0] rdata;
   logic       irq1, irq1_oe, irq2, irq2_oe, wake, t_single, t_full, irq, pin2;
   int         n_mismatch, n_tests, cnt;

   icfg_top #(.PULSE_CYCLES(PC)) dut (
      .CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .SOFT_RESET_I(srst), .HIBERNATE_I(hib), .DATA_READ_I(dread),
      .DATA_READY_EVENT_I(ev_dr), .OUTSIDE_THR_EVENT_I(ev_ot), .ORIENT_EVENT_I(ev_or),
      .EXTRA_EVENTS_I(ev_x), .BOOT_MODE_STRAP_I(strap), .IRQ2_PIN_I(pin2), .IRQ1_O(irq1),
      .IRQ1_OE_O(irq1_oe), .IRQ2_O(irq2), .IRQ2_OE_O(irq2_oe), .WAKE_HOLD_O(wake),
      .TRIG_SINGLE_O(t_single), .TRIG_FULL_O(t_full), .IRQ_O(irq));
   icfg_host host (.clk_i(clk), .trig_req_i(treq), .drive_i(tdrv), .dev_out_i(irq2),
      .dev_oe_i(irq2_oe), .pin_o(pin2));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [7:0] exp_pin(input logic act, input logic od, input logic pol);
      return od ? {6'h00, act, pol} : {6'h00, 1'b1, act ~^ pol};
   endfunction : exp_pin

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr8

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask : rdchk

   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: ev_dr <= 1'b1;
         1: ev_ot <= 1'b1;
         2: ev_or <= 1'b1;
         3: dread <= 1'b1;
         4: srst <= 1'b1;
         5: hib <= 1'b1;
         default: treq <= 1'b1;
      endcase
      @(posedge clk);
      {ev_dr, ev_ot, ev_or, dread, srst, hib, treq} <= 7'h00;
      #1;
   endtask : pulse

   // single starts count 1, full starts count 16
   task automatic trig_count;
      cnt = 0;
      repeat (10) begin
         tick(1);
         if (t_single !== 1'b0) cnt += 1;
         if (t_full !== 1'b0) cnt += 16;
      end
   endtask : trig_count

   initial begin
      {arst_n, wr, rd, srst, hib, dread, ev_dr, ev_ot, ev_or, strap, treq, tdrv} = '0;
      addr = 8'h00;
      wdata = 8'h00;
      ev_x = 5'h00;
      n_mismatch = 0;
      n_tests = 0;
      void'($urandom(32'hff5e7f8f));
      tick(8);
      arst_n <= 1'b1;
      tick(2);
      rdchk(`ICFG_ADDR_CFG4, 8'h01);
      rdchk(`ICFG_ADDR_STATUS, 8'h00);
      rdchk(8'h40, 8'h00);
      chk({6'h00, irq1_oe, irq1}, 8'h02);
      // bit 2 kept low: a stray trigger edge would upset the pin checks
      for (int i = 0; i < 6; i++) begin
         v = 8'($urandom) & 8'hfb;
         wr8(`ICFG_ADDR_CFG4, v);
         rdchk(`ICFG_ADDR_CFG4, v);
      end
      wr8(`ICFG_ADDR_MASK, 8'h07);
      for (int i = 0; i < 4; i++) begin
         wr8(`ICFG_ADDR_CFG4, 8'(i));
         pulse(0);
         tick(5);
         chk({6'h00, irq1_oe, irq1}, exp_pin(1'b1, i[1], i[0]));
         pulse(3);
         tick(1);
         chk({6'h00, irq1_oe, irq1}, exp_pin(1'b0, i[1], i[0]));
      end
      wr8(`ICFG_ADDR_CFG4, 8'h09);
      pulse(0);
      cnt = 0;
      repeat (PC + 12) begin
         tick(1);
         if (irq1 !== 1'b0) cnt++;
      end
      chk(8'(cnt), 8'(PC));
      pulse(1);
      tick(1);
      chk({7'h00, irq1}, 8'h01);
      wr8(`ICFG_ADDR_STATUS, 8'hff);
      for (int i = 0; i < 8; i++) begin
         wr8(`ICFG_ADDR_CFG4, {2'b00, i[1:0], 4'h1});
         pulse(i[2] ? 2 : 1);
         chk({7'h00, wake}, {7'h00, i[2] ? i[0] : i[1]});
      end
      wr8(`ICFG_ADDR_STATUS, 8'hff);
      wr8(`ICFG_ADDR_MASK, 8'h00);
      v = 8'($urandom) | 8'h01;
      @(posedge clk);
      ev_x <= v[4:0];
      @(posedge clk);
      ev_x <= 5'h00;
      tick(1);
      rdchk(`ICFG_ADDR_STATUS, {v[4:0], 3'b000});
      chk({7'h00, irq}, 8'h00);
      wr8(`ICFG_ADDR_MASK, 8'hf8);
      tick(1);
      chk({7'h00, irq}, 8'h01);
      wr8(`ICFG_ADDR_STATUS, {v[4:0], 3'b000});
      tick(1);
      chk({7'h00, irq}, 8'h00);
      wr8(`ICFG_ADDR_MASK, 8'h07);
      wr8(`ICFG_ADDR_ROUTE, 8'h02);
      wr8(`ICFG_ADDR_CFG4, 8'h01);
      pulse(1);
      tick(1);
      chk({4'h0, irq2_oe, irq2, irq1_oe, irq1}, 8'h0e);
      wr8(`ICFG_ADDR_STATUS, 8'hff);
      tdrv <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         wr8(`ICFG_ADDR_CFG4, {m[0], 7'h05});
         pulse(1);
         tick(2);
         chk({7'h00, irq2_oe}, 8'h00);
         rdchk(`ICFG_ADDR_SYSMODE, 8'h01);
         pulse(6);
         trig_count();
         chk(8'(cnt), m ? 8'h10 : 8'h01);
      end
      wr8(`ICFG_ADDR_CFG4, 8'hf3);
      pulse(4);
      tick(1);
      rdchk(`ICFG_ADDR_CFG4, 8'h03);
      rdchk(`ICFG_ADDR_ROUTE, 8'h00);
      pulse(5);
      tick(1);
      rdchk(`ICFG_ADDR_CFG4, 8'h01);
      arst_n <= 1'b0;
      strap <= 1'b1;
      tick(8);
      arst_n <= 1'b1;
      tick(8);
      rdchk(`ICFG_ADDR_SYSMODE, 8'h02);
      wr8(`ICFG_ADDR_CFG4, 8'h0f);
      wr8(`ICFG_ADDR_MASK, 8'h01);
      pulse(0);
      tick(PC + 4);
      chk({6'h00, irq1_oe, irq1}, 8'h02);
      pulse(6);
      trig_count();
      chk(8'(cnt), 8'h00);
      rdchk(`ICFG_ADDR_SYSMODE, 8'h02);
      complete_run();
   end
endmodule : tb
`default_nettype wire
